// >>> hdl/tfc_defs.svh
`ifndef TFC_DEFS_SVH
`define TFC_DEFS_SVH
// ****************************************************************
// Register map of the host controller (byte addresses)
// ****************************************************************
`define TFC_OFS_CTRL 5'h00
`define TFC_OFS_CMD 5'h04
`define TFC_OFS_STATUS 5'h08
`define TFC_OFS_IRQ_STAT 5'h0c
`define TFC_OFS_IRQ_MASK 5'h10
// Control fields
`define TFC_CTRL_DAMP 0
`define TFC_CTRL_RAW 1
`define TFC_CTRL_RAW_SCL 2
`define TFC_CTRL_RAW_SDA 3
`define TFC_CTRL_RST 4'h0
// Status fields
`define TFC_ST_FIELD 0
`define TFC_ST_BUSY 1
`define TFC_ST_CNT_LSB 16
// Interrupt bits
`define TFC_IRQ_RISE 0
`define TFC_IRQ_GAP 1
`define TFC_IRQ_DONE 2
// ****************************************************************
// Serial control byte: A4..A0 C1 C0 RW
// ****************************************************************
`define TFC_MODE_SPECIAL 2'h3
`define TFC_SPC_AUTO_OFF 5'h00
`define TFC_SPC_AUTO_ON 5'h01
`define TFC_SPC_ENC_BIPHASE 5'h02
`define TFC_SPC_ENC_MANCH 5'h03
`define TFC_SPC_ENC_OFF 5'h04
// ****************************************************************
// Timing
// ****************************************************************
`define TFC_CLK_HZ 125000000
`define TFC_MAX_BAUD 10000
`define TFC_BIT_CYC ((`TFC_CLK_HZ + `TFC_MAX_BAUD - 1) / `TFC_MAX_BAUD)
`define TFC_SCL_HALF_NS 5000
`define TFC_SCL_HALF_CYC ((`TFC_SCL_HALF_NS + 7) / 8)
`endif

// >>> hdl/tfc_pkg.sv
package tfc_pkg;
   // Host serial sequencer states
   typedef enum logic [1:0] {TFC_IDLE, TFC_START, TFC_BITS, TFC_STOP} tfc_ser_st_t;
   // Encoder mode held by the device
   typedef enum logic [1:0] {TFC_ENC_OFF, TFC_ENC_BIPHASE, TFC_ENC_MANCH} tfc_enc_t;
endpackage

// >>> hdl/tfc_link_if.sv
`timescale 1ns/1ns
// ****************************************************************
// Link between host controller and front end
// ****************************************************************
interface tfc_link_if;
   logic damp; // Damping control, host drives
   logic field_ind; // Field present indicator, device drives
   logic field_clk; // Extracted field clock, device drives
   logic scl; // Serial clock, host drives push-pull
   logic sda_h_o; // Host serial data out
   logic sda_h_oe_n; // Host drive enable, low drives
   logic sda_d_o; // Device serial data out
   logic sda_d_oe_n; // Device drive enable, low drives
   logic sda; // Resolved open-drain line with pull-up
   assign sda = ~((~sda_h_oe_n & ~sda_h_o) | (~sda_d_oe_n & ~sda_d_o));
   modport dev (input damp, input scl, input sda, output field_ind, output field_clk,
      output sda_d_o, output sda_d_oe_n);
   modport host (output damp, output scl, input sda, input field_ind, input field_clk,
      output sda_h_o, output sda_h_oe_n);
endinterface

// >>> hdl/tfc_dev.sv
`timescale 1ns/1ns
`include "tfc_defs.svh"
// Notes on behaviour
// [R1] Damp coil while damping input high
// [R2] Host drives damping input per modulation state
// [R3] Reset mode: high damping boosts start-up charging
// [R4] Indicator high with field, low otherwise
// [R5] Host decodes gaps itself from indicator
// [R6] Extracted carrier clock drives field clock output
// [R7] Automatic mode: field supply while field present
// [R8] Serial command disables switching, battery stays
// [R9] Special modes only via special control bytes
// [R10] Encoder turns serial stream into coded damping
// [R11] Damping path supports return rate to limit
// [R12] Disable holds until reset or switch-on command
// [R13] Field indication synchronised before clocked use
module tfc_dev (
   input wire logic clk_i,
   input wire logic rst_n_i,
   tfc_link_if.dev link,
   input wire logic coil_field_i,
   input wire logic carrier_clk_i,
   output logic damp_o,
   output logic field_supply_o,
   output logic charge_boost_o,
   output logic wake_o,
   output logic auto_sw_o,
   output tfc_pkg::tfc_enc_t enc_mode_o
);
   import tfc_pkg::*;

   // ****************************************************************
   // Synchronisers for every pin from outside the clock domain
   // ****************************************************************
   logic [4:0] sync1_q; // First stages, read only by second stages
   logic [4:0] sync2_q; // Second stages, safe to use
   logic [4:0] pins_w; // Raw pin bundle
   localparam logic [4:0] SYNC_RST = 5'h03; // Serial lines idle high, so no false edge
   assign pins_w = {coil_field_i, carrier_clk_i, link.damp, link.scl, link.sda};

   // Two stages per pin, one generate loop over the bundle
   genvar gi;
   generate
      for (gi = 0; gi < 5; gi = gi + 1)
      begin : g_sync
         always_ff @(posedge clk_i)
         begin
            if (!rst_n_i)
            begin
               sync1_q[gi] <= SYNC_RST[gi];
               sync2_q[gi] <= SYNC_RST[gi];
            end
            else
            begin
               sync1_q[gi] <= pins_w[gi];
               sync2_q[gi] <= sync1_q[gi]; // [R13]
            end
         end
      end
   endgenerate

   logic field_s; // Synchronised field presence
   logic carrier_s; // Synchronised carrier clock
   logic damp_s; // Synchronised damping request
   logic scl_s; // Synchronised serial clock
   logic sda_s; // Synchronised serial data
   assign {field_s, carrier_s, damp_s, scl_s, sda_s} = sync2_q;

   // ****************************************************************
   // Edge detection on the serial lines
   // ****************************************************************
   logic scl_d_q; // Previous serial clock
   logic sda_d_q; // Previous serial data
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         scl_d_q <= 1'b1;
         sda_d_q <= 1'b1;
      end
      else
      begin
         scl_d_q <= scl_s;
         sda_d_q <= sda_s;
      end
   end
   wire scl_rise_w = scl_s & ~scl_d_q;
   wire scl_fall_w = ~scl_s & scl_d_q;
   // Data moves while clock high only for frame markers
   wire start_w = scl_s & scl_d_q & sda_d_q & ~sda_s;
   wire stop_w = scl_s & scl_d_q & ~sda_d_q & sda_s;

   // ****************************************************************
   // Control byte receiver
   // ****************************************************************
   logic in_frame_q; // Between start and stop
   logic [7:0] shift_q; // Incoming control byte
   logic [3:0] bit_cnt_q; // Bits taken in this frame
   logic byte_ok_q; // Byte complete, command already decoded
   logic ack_q; // Pulling data low for acknowledge

   wire byte_done_w = in_frame_q & scl_rise_w & (bit_cnt_q == 4'h7);
   wire [7:0] byte_w = {shift_q[6:0], sda_s};
   wire special_w = byte_done_w & (byte_w[2:1] == `TFC_MODE_SPECIAL);
   wire [4:0] spc_w = byte_w[7:3];

   // Shift on rising clock; bits after the first byte are ignored
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         in_frame_q <= 1'b0;
         shift_q <= 8'h00;
         bit_cnt_q <= 4'h0;
         byte_ok_q <= 1'b0;
      end
      else if (start_w)
      begin
         in_frame_q <= 1'b1;
         bit_cnt_q <= 4'h0;
         byte_ok_q <= 1'b0;
      end
      else if (stop_w)
      begin
         in_frame_q <= 1'b0;
      end
      else if (in_frame_q & scl_rise_w & ~byte_ok_q)
      begin
         shift_q <= byte_w;
         bit_cnt_q <= bit_cnt_q + 4'h1;
         byte_ok_q <= byte_done_w;
      end
   end

   // Acknowledge: low from the fall after bit 8 to the fall after bit 9
   logic ack_arm_q; // Byte taken, acknowledge clock pending
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         ack_arm_q <= 1'b0;
         ack_q <= 1'b0;
      end
      else if (start_w | stop_w)
      begin
         ack_arm_q <= 1'b0;
         ack_q <= 1'b0;
      end
      else if (byte_done_w)
      begin
         ack_arm_q <= 1'b1;
      end
      else if (scl_fall_w & ack_arm_q)
      begin
         ack_arm_q <= 1'b0;
         ack_q <= 1'b1;
      end
      else if (scl_fall_w)
      begin
         ack_q <= 1'b0;
      end
   end

   // ****************************************************************
   // Operating modes, changed only by special control bytes
   // ****************************************************************
   logic auto_q; // Automatic supply switching enabled
   tfc_enc_t enc_cfg_q; // Encoder chosen by the last command
   logic enc_run_q; // Encoder drives damping until next start
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         auto_q <= 1'b1; // Power-on state is automatic
         enc_cfg_q <= TFC_ENC_OFF;
      end
      else if (special_w) // [R9]
      begin
         case (spc_w)
            `TFC_SPC_AUTO_OFF: auto_q <= 1'b0; // [R8]
            `TFC_SPC_AUTO_ON: auto_q <= 1'b1; // [R12]
            `TFC_SPC_ENC_BIPHASE: enc_cfg_q <= TFC_ENC_BIPHASE;
            `TFC_SPC_ENC_MANCH: enc_cfg_q <= TFC_ENC_MANCH;
            `TFC_SPC_ENC_OFF: enc_cfg_q <= TFC_ENC_OFF;
            default: auto_q <= auto_q; // Unknown special codes do nothing
         endcase
      end
   end

   // The stream only runs outside frames, so a start ends it cleanly
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         enc_run_q <= 1'b0;
      end
      else if (start_w)
      begin
         enc_run_q <= 1'b0;
      end
      else if (stop_w)
      begin
         enc_run_q <= (enc_cfg_q != TFC_ENC_OFF); // [R10]
      end
   end

   // ****************************************************************
   // Encoder: serial clock is the bit clock, data is the bit
   // ****************************************************************
   logic biph_q; // Bi-phase mark level
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         biph_q <= 1'b0;
      end
      else if (enc_run_q & scl_rise_w)
      begin
         biph_q <= ~biph_q; // Level change at every bit boundary [R10]
      end
      else if (enc_run_q & scl_fall_w & sda_s)
      begin
         biph_q <= ~biph_q; // Extra change mid-bit for a one [R10]
      end
   end
   // Manchester: first half carries the bit, second its inverse
   wire manch_w = sda_s ^ ~scl_s;
   wire enc_bit_w = (enc_cfg_q == TFC_ENC_MANCH) ? manch_w : biph_q;

   // ****************************************************************
   // Damping, supply and indicator outputs
   // ****************************************************************
   logic damp_q; // Coil damping stage
   logic supply_q; // Field supply selected
   logic boost_q; // Start-up charge assist
   logic reset_mode_q; // Still in reset mode, no field supply yet
   logic ind_q; // Field present indicator pin
   logic fclk_q; // Field clock pin
   logic sda_oe_n_q; // Acknowledge drive
   // Three cycles of latency against a bit of 12500 cycles at the limit
   wire damp_sel_w = enc_run_q ? enc_bit_w : damp_s; // [R11]

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         damp_q <= 1'b0;
         supply_q <= 1'b0;
         boost_q <= 1'b0;
         reset_mode_q <= 1'b1;
         ind_q <= 1'b0;
         fclk_q <= 1'b0;
         sda_oe_n_q <= 1'b1;
      end
      else
      begin
         damp_q <= damp_sel_w; // [R1]
         supply_q <= auto_q & field_s; // [R7] [R8]
         if (supply_q)
         begin
            reset_mode_q <= 1'b0; // Field supply reached, start-up over
         end
         boost_q <= reset_mode_q & damp_s; // [R3]
         ind_q <= field_s; // [R4]
         fclk_q <= carrier_s; // [R6]
         sda_oe_n_q <= ~ack_q;
      end
   end

   assign damp_o = damp_q;
   assign field_supply_o = supply_q;
   assign charge_boost_o = boost_q;
   assign wake_o = ind_q;
   assign auto_sw_o = auto_q;
   assign enc_mode_o = enc_cfg_q;
   assign link.field_ind = ind_q;
   assign link.field_clk = fclk_q;
   assign link.sda_d_o = 1'b0; // Open drain: only ever pulls low
   assign link.sda_d_oe_n = sda_oe_n_q;
endmodule

// >>> hdl/tfc_host.sv
`timescale 1ns/1ns
`include "tfc_defs.svh"
module tfc_host #(
   parameter int HALF_CYC = `TFC_SCL_HALF_CYC
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   tfc_link_if.host link,
   input wire logic [4:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   output logic irq_o
);
   import tfc_pkg::*;

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   logic [1:0] s1_q; // First stages
   logic [1:0] s2_q; // Second stages
   logic [1:0] s3_q; // Previous value for edges
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         s1_q <= 2'h0;
         s2_q <= 2'h0;
         s3_q <= 2'h0;
      end
      else
      begin
         s1_q <= {link.field_ind, link.field_clk};
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end
   wire field_w = s2_q[1];
   wire rise_w = s2_q[1] & ~s3_q[1];
   wire gap_w = ~s2_q[1] & s3_q[1]; // Gap or field loss seen [R5]
   wire fclk_edge_w = s2_q[0] & ~s3_q[0];

   // ****************************************************************
   // Avalon slave: one wait state, then accept
   // ****************************************************************
   logic wait_q; // Waitrequest, high when idle
   logic [31:0] rdata_q; // Read data, valid while wait is low
   logic [3:0] ctrl_q; // Control register
   logic [2:0] ist_q; // Sticky interrupt status
   logic [2:0] imask_q; // Interrupt mask
   logic [15:0] fcnt_q; // Field clock rising edges, wraps
   logic irq_q; // Interrupt line
   wire req_w = avs_read_i | avs_write_i;
   wire wr_w = avs_write_i & ~wait_q;
   wire wr_ctrl_w = wr_w & (avs_address_i == `TFC_OFS_CTRL);
   wire wr_cmd_w = wr_w & (avs_address_i == `TFC_OFS_CMD);
   wire wr_ist_w = wr_w & (avs_address_i == `TFC_OFS_IRQ_STAT);
   wire wr_imask_w = wr_w & (avs_address_i == `TFC_OFS_IRQ_MASK);
   logic busy_q; // Serial sequence running
   logic done_w; // Sequence ends this cycle
   wire [2:0] ev_w = {done_w, gap_w, rise_w};
   wire [31:0] status_w = {fcnt_q, 14'h0000, busy_q, field_w};
   // Unmapped addresses read as zero
   wire [31:0] rmux_w =
      (avs_address_i == `TFC_OFS_CTRL) ? {28'h0000000, ctrl_q} :
      (avs_address_i == `TFC_OFS_STATUS) ? status_w :
      (avs_address_i == `TFC_OFS_IRQ_STAT) ? {29'h00000000, ist_q} :
      (avs_address_i == `TFC_OFS_IRQ_MASK) ? {29'h00000000, imask_q} : 32'h00000000;

   // Wait drops for exactly one cycle per request
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         wait_q <= 1'b1;
         rdata_q <= 32'h00000000;
      end
      else
      begin
         wait_q <= ~(req_w & wait_q);
         rdata_q <= rmux_w;
      end
   end

   // Registers; a hardware event wins over a clear in the same cycle
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         ctrl_q <= `TFC_CTRL_RST;
         ist_q <= 3'h0;
         imask_q <= 3'h0;
         fcnt_q <= 16'h0000;
         irq_q <= 1'b0;
      end
      else
      begin
         if (wr_ctrl_w)
         begin
            ctrl_q <= avs_writedata_i[3:0];
         end
         if (wr_imask_w)
         begin
            imask_q <= avs_writedata_i[2:0];
         end
         ist_q <= (ist_q & ~(wr_ist_w ? avs_writedata_i[2:0] : 3'h0)) | ev_w;
         if (fclk_edge_w)
         begin
            fcnt_q <= fcnt_q + 16'h0001;
         end
         irq_q <= |(ist_q & imask_q);
      end
   end

   // ****************************************************************
   // Serial sequencer for one control byte
   // ****************************************************************
   tfc_ser_st_t st_q; // Sequencer state
   logic [15:0] div_q; // Half period divider
   logic [4:0] step_q; // Phase within state
   logic [7:0] byte_q; // Byte being sent
   logic scl_q; // Serial clock pin
   logic sda_q; // Open-drain data: 1 releases
   wire tick_w = (div_q == 16'(HALF_CYC - 1));
   assign done_w = (st_q == TFC_STOP) & tick_w & (step_q == 5'h02);
   // Acknowledge slot (step 16,17) releases the line
   wire bit_w = (step_q[4:1] == 4'h8) ? 1'b1 : byte_q[3'h7 - step_q[3:1]];

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         st_q <= TFC_IDLE;
         div_q <= 16'h0000;
         step_q <= 5'h00;
         byte_q <= 8'h00;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         busy_q <= 1'b0;
      end
      else
      begin
         div_q <= (tick_w | (st_q == TFC_IDLE)) ? 16'h0000 : div_q + 16'h0001;
         case (st_q)
            TFC_IDLE:
            begin
               // A command written while busy is dropped
               if (wr_cmd_w)
               begin
                  byte_q <= avs_writedata_i[7:0];
                  busy_q <= 1'b1;
                  st_q <= TFC_START;
               end
               scl_q <= ctrl_q[`TFC_CTRL_RAW] ? ctrl_q[`TFC_CTRL_RAW_SCL] : 1'b1;
               sda_q <= ctrl_q[`TFC_CTRL_RAW] ? ctrl_q[`TFC_CTRL_RAW_SDA] : 1'b1;
            end
            TFC_START:
            begin
               scl_q <= 1'b1;
               if (tick_w)
               begin
                  sda_q <= 1'b0; // Data falls while clock high
                  st_q <= TFC_BITS;
                  step_q <= 5'h00;
               end
            end
            TFC_BITS:
            begin
               if (tick_w)
               begin
                  scl_q <= step_q[0];
                  if (!step_q[0])
                  begin
                     sda_q <= bit_w;
                  end
                  step_q <= (step_q == 5'h11) ? 5'h00 : step_q + 5'h01;
                  st_q <= (step_q == 5'h11) ? TFC_STOP : TFC_BITS;
               end
            end
            TFC_STOP:
            begin
               if (tick_w)
               begin
                  scl_q <= (step_q != 5'h00);
                  sda_q <= (step_q == 5'h02);
                  step_q <= step_q + 5'h01;
                  if (step_q == 5'h02)
                  begin
                     busy_q <= 1'b0;
                     st_q <= TFC_IDLE;
                  end
               end
            end
            default: st_q <= TFC_IDLE;
         endcase
      end
   end

   assign avs_readdata_o = rdata_q;
   assign avs_waitrequest_o = wait_q;
   assign irq_o = irq_q;
   assign link.damp = ctrl_q[`TFC_CTRL_DAMP]; // One level per modulation state [R2]
   assign link.scl = scl_q;
   assign link.sda_h_o = 1'b0;
   assign link.sda_h_oe_n = sda_q;
endmodule

// >>> tb/tfc_link_props.sv
`timescale 1ns/1ns
// ****
// Link checker
// ****
module tfc_link_props (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic damp,
   input wire logic field_ind,
   input wire logic field_clk,
   input wire logic scl,
   input wire logic sda,
   input wire logic sda_d_oe_n,
   input wire logic coil_field_i,
   input wire logic carrier_clk_i,
   input wire logic damp_o,
   input wire logic field_supply_o,
   input wire logic auto_sw_o,
   input wire tfc_pkg::tfc_enc_t enc_mode_o
);
   import tfc_pkg::*;
   logic scl_q, sda_q; // Wire levels one cycle back
   logic frm_q, frm_d; // Frame open on the wire
   logic [4:0] gap_q, gap_d; // Cycles since the frame closed
   wire start_w = sda_q & ~sda & scl & scl_q;
   wire stop_w = ~sda_q & sda & scl;
   assign frm_d = start_w ? 1'b1 : (stop_w ? 1'b0 : frm_q);
   assign gap_d = frm_q ? 5'h00 : ((gap_q == 5'h1f) ? gap_q : gap_q + 5'h01);
   // Frame tracker; saturates so a long idle never wraps
   always_ff @(posedge clk_i)
   begin
      scl_q <= scl;
      sda_q <= sda;
      frm_q <= rst_n_i ? frm_d : 1'b0;
      gap_q <= rst_n_i ? gap_d : 5'h1f;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   property p_damp;
      (enc_mode_o == TFC_ENC_OFF) [*4] |-> damp_o == $past(damp, 3);
   endproperty
   a_damp: assert property (p_damp) else $error("damping lost");
   property p_ind;
      field_ind == $past(coil_field_i, 3);
   endproperty
   a_ind: assert property (p_ind) else $error("field indicator wrong");
   property p_fclk;
      field_clk == $past(carrier_clk_i, 3);
   endproperty
   a_fclk: assert property (p_fclk) else $error("field clock wrong");
   property p_sup;
      auto_sw_o [*3] |-> field_supply_o == $past(coil_field_i, 3);
   endproperty
   a_sup: assert property (p_sup) else $error("supply choice wrong");
   property p_batt;
      !auto_sw_o [*2] |-> !field_supply_o;
   endproperty
   a_batt: assert property (p_batt) else $error("field supply while off");
   property p_mode;
      $changed(auto_sw_o) || $changed(enc_mode_o) |-> gap_q < 5'h14;
   endproperty
   a_mode: assert property (p_mode) else $error("mode changed off frame");
   property p_ack_frm;
      !sda_d_oe_n |-> frm_q;
   endproperty
   a_ack_frm: assert property (p_ack_frm) else $error("data driven off frame");
   property p_ack_len;
      $fell(sda_d_oe_n) |-> !sda_d_oe_n [*6] ##[1:8] sda_d_oe_n;
   endproperty
   a_ack_len: assert property (p_ack_len) else $error("ack length wrong");
   c_field: cover property ($rose(field_ind));
   c_ack: cover property ($fell(sda_d_oe_n));
   c_auto: cover property ($fell(auto_sw_o));
endmodule

// >>> tb/test_transponder_frontend_control.sv
`timescale 1ns/1ns
`include "tfc_defs.svh"
// ****
// Bench
// ****
module test_transponder_frontend_control;
   import tfc_pkg::*;
   logic clk_i, rst_n_i, coil_field_i, carrier_clk_i, car_en, b = 1'b0;
   logic [4:0] avs_address_i;
   logic avs_read_i, avs_write_i, avs_waitrequest_o, irq_o;
   logic [31:0] avs_writedata_i, avs_readdata_o, rd, c0;
   logic damp_o, field_supply_o, charge_boost_o, wake_o, auto_sw_o;
   tfc_enc_t enc_mode_o;
   int num_errors = 0, compares = 0, rises = 0, r0;
   logic [15:0] lfsr = 16'h401f; // Fixed seed keeps runs repeatable
   logic [1:0] seq [0:6] = '{2'b10, 2'b00, 2'b01, 2'b00, 2'b10, 2'b11, 2'b10}; // {sda,scl}
   tfc_link_if i_tfc_link_if ();
   tfc_dev i_tfc_dev (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(i_tfc_link_if),
      .coil_field_i(coil_field_i), .carrier_clk_i(carrier_clk_i), .damp_o(damp_o),
      .field_supply_o(field_supply_o), .charge_boost_o(charge_boost_o), .wake_o(wake_o),
      .auto_sw_o(auto_sw_o), .enc_mode_o(enc_mode_o));
   tfc_host #(.HALF_CYC(4)) i_tfc_host (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .link(i_tfc_link_if), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
      .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
      .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o));
   tfc_link_props i_tfc_link_props (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .damp(i_tfc_link_if.damp), .field_ind(i_tfc_link_if.field_ind),
      .field_clk(i_tfc_link_if.field_clk), .scl(i_tfc_link_if.scl), .sda(i_tfc_link_if.sda),
      .sda_d_oe_n(i_tfc_link_if.sda_d_oe_n), .coil_field_i(coil_field_i),
      .carrier_clk_i(carrier_clk_i), .damp_o(damp_o), .field_supply_o(field_supply_o),
      .auto_sw_o(auto_sw_o), .enc_mode_o(enc_mode_o));
   // Clock and a free carrier; NBA keeps carrier edges on a clock edge race free
   initial
   begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   initial
   begin
      carrier_clk_i = 1'b0;
      #3;
      forever
      begin
         #62 carrier_clk_i <= car_en;
         if (car_en)
            rises++;
         #63 carrier_clk_i <= 1'b0;
      end
   end
   function logic [15:0] nxt(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   function logic man(input logic [1:0] s); // Manchester level from {sda,scl}
      return s[1] ^ ~s[0];
   endfunction
   function logic bip(input logic [1:0] p, input logic [1:0] c); // Bi-phase toggle
      return (c[0] & ~p[0]) | (~c[0] & p[0] & c[1]);
   endfunction
   task conclude;
      $display("compares=%0d num_errors=%0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task chk_reg(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         num_errors++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task chk_pin(input logic got, input logic exp);
      chk_reg({31'h0, got}, {31'h0, exp});
   endtask
   task waitc(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // One Avalon access; held until waitrequest is seen low at a rising edge
   task acc(input logic w, input logic [4:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= w;
      avs_read_i <= ~w;
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (avs_waitrequest_o !== 1'b0 && n < 50);
      rd = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
      chk_pin(n < 50, 1'b1);
   endtask
   task cmd(input logic [4:0] code, input logic [1:0] md);
      int n;
      acc(1'b1, `TFC_OFS_CMD, {24'h0, code, md, 1'b0});
      n = 0;
      do
      begin
         acc(1'b0, `TFC_OFS_STATUS, 32'h0);
         n++;
      end
      while (rd[`TFC_ST_BUSY] !== 1'b0 && n < 100);
      waitc(8); // Device sees the stop a few cycles late
      chk_pin(irq_o, 1'b1);
      acc(1'b1, `TFC_OFS_IRQ_STAT, 32'h4);
   endtask
   task do_reset;
      rst_n_i <= 1'b0;
      waitc(16);
      rst_n_i <= 1'b1;
   endtask
   initial
   begin
      #600000;
      num_errors++;
      conclude();
   end
   initial
   begin
      rst_n_i = 1'b0;
      coil_field_i = 1'b0;
      car_en = 1'b0;
      avs_address_i = 5'h00;
      avs_read_i = 1'b0;
      avs_write_i = 1'b0;
      avs_writedata_i = 32'h0;
      waitc(16);
      rst_n_i <= 1'b1;
      acc(1'b1, 5'h1c, 32'hffffffff);
      acc(1'b0, 5'h1c, 32'h0);
      chk_reg(rd, 32'h0);
      chk_pin(auto_sw_o, 1'b1);
      acc(1'b1, `TFC_OFS_CTRL, 32'h1);
      waitc(6);
      chk_pin(charge_boost_o, 1'b1);
      acc(1'b1, `TFC_OFS_CTRL, 32'h0);
      acc(1'b1, `TFC_OFS_IRQ_MASK, 32'h1);
      coil_field_i <= 1'b1;
      waitc(8);
      chk_pin(irq_o, 1'b1);
      chk_pin(wake_o, 1'b1);
      acc(1'b1, `TFC_OFS_IRQ_STAT, 32'h1);
      waitc(3);
      chk_pin(irq_o, 1'b0);
      acc(1'b1, `TFC_OFS_CTRL, 32'h1);
      waitc(6);
      chk_pin(charge_boost_o, 1'b0);
      $display("test reset mode done");
      for (int i = 0; i < 10; i++)
      begin
         lfsr = nxt(lfsr);
         acc(1'b1, `TFC_OFS_CTRL, {31'h0, lfsr[0]});
         coil_field_i <= lfsr[1];
         waitc(6);
         chk_pin(damp_o, lfsr[0]);
         chk_pin(field_supply_o, lfsr[1]);
         acc(1'b0, `TFC_OFS_STATUS, 32'h0);
         chk_pin(rd[`TFC_ST_FIELD], lfsr[1]);
      end
      $display("test random levels done");
      acc(1'b1, `TFC_OFS_IRQ_MASK, 32'h4);
      coil_field_i <= 1'b1;
      cmd(`TFC_SPC_AUTO_OFF, `TFC_MODE_SPECIAL);
      chk_pin(field_supply_o, 1'b0);
      chk_pin(i_tfc_link_if.field_ind, 1'b1);
      cmd(`TFC_SPC_AUTO_ON, 2'h1);
      cmd(5'h05, `TFC_MODE_SPECIAL);
      chk_pin(auto_sw_o, 1'b0);
      cmd(`TFC_SPC_AUTO_ON, `TFC_MODE_SPECIAL);
      waitc(6);
      chk_pin(field_supply_o, 1'b1);
      // Bi-phase then Manchester over one raw line pattern
      for (int m = 0; m < 2; m++)
      begin
         cmd(m ? `TFC_SPC_ENC_MANCH : `TFC_SPC_ENC_BIPHASE, `TFC_MODE_SPECIAL);
         chk_reg({30'h0, enc_mode_o}, {30'h0, (m ? TFC_ENC_MANCH : TFC_ENC_BIPHASE)});
         for (int i = 0; i < 7; i++)
         begin
            acc(1'b1, `TFC_OFS_CTRL, {28'h0, seq[i], 2'h2});
            b = b ^ bip(i ? seq[i - 1] : 2'h3, seq[i]);
            waitc(6);
            chk_pin(damp_o, m ? man(seq[i]) : b);
         end
         acc(1'b1, `TFC_OFS_CTRL, 32'h0);
         cmd(`TFC_SPC_ENC_OFF, `TFC_MODE_SPECIAL);
         chk_reg({30'h0, enc_mode_o}, {30'h0, TFC_ENC_OFF});
      end
      $display("test special modes done");
      acc(1'b0, `TFC_OFS_STATUS, 32'h0);
      c0 = rd;
      r0 = rises;
      car_en <= 1'b1;
      waitc(200);
      car_en <= 1'b0;
      waitc(40);
      acc(1'b0, `TFC_OFS_STATUS, 32'h0);
      chk_reg({16'h0, rd[31:16] - c0[31:16]}, rises - r0);
      $display("test field clock done");
      cmd(`TFC_SPC_AUTO_OFF, `TFC_MODE_SPECIAL);
      coil_field_i <= 1'b0;
      waitc(6);
      do_reset();
      waitc(2);
      chk_pin(auto_sw_o, 1'b1);
      $display("test reset release done");
      conclude();
   end
endmodule
